// ### hw/btn_if.sv
`timescale 1ns/1ps
interface btn_if;
    logic left_press;
    logic right_press;
    logic both_press;
    modport producer (output left_press, output right_press, output both_press);
    modport consumer (input left_press, input right_press, input both_press);
endinterface

// ### hw/button_decoder.sv
`timescale 1ns/1ps
`include "stat_consts.svh"
module button_decoder (
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    input  wire logic   left_btn,
    input  wire logic   right_btn,
    btn_if.producer     ev
);
    typedef struct packed {
        logic left_prev;
        logic right_prev;
        logic both_held;
    } btn_s;

    btn_s s_q;
    btn_s s_d;

    // Both held suppresses single presses until full release
    always_comb begin
        s_d = s_q;
        s_d.left_prev = left_btn;
        s_d.right_prev = right_btn;
        if (left_btn && right_btn) begin
            s_d.both_held = 1'b1;
        end else if (!left_btn && !right_btn) begin
            s_d.both_held = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ev.both_press  = left_btn && right_btn && !s_q.both_held;
    assign ev.left_press  = !left_btn && s_q.left_prev && !right_btn && !s_q.both_held;
    assign ev.right_press = !right_btn && s_q.right_prev && !left_btn && !s_q.both_held;
endmodule

// ### hw/line_error_stat_display.sv
`timescale 1ns/1ps
`include "stat_consts.svh"
// Operation
// - A second holding at least one error event counts as an errored second.
// - A frame whose computed CRC differs from the received CRC is a checksum mismatch.
// - A second with more than one but fewer than 320 CRC mismatches is a bursty second.
// - Each cycle with a CRC mismatch or a loss of frame is one error event.
// - A second with 320 or more CRC mismatches is a severely errored second.
// - Each received framing bit differing from its expected value is counted.
// - In AMI every bipolar violation counts, in B8ZS only non-substitution ones.
// - Channel view shows the channel number and drives the LEDs from its signals.
// - Right button steps the selected channel through 24 channels.
// - Left button selects node views 1 to 8, whose LEDs act as the activity chase.
// - Pressing both buttons clears the statistics counters.
// - Activity view chases LEDs left to right, faster with more activity.
module line_error_stat_display (
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    input  wire logic                  frame_done,
    input  wire logic [5:0]            crc_local,
    input  wire logic [5:0]            crc_rx,
    input  wire logic                  loss_of_frame,
    input  wire logic                  framing_bit_valid,
    input  wire logic                  framing_bit_rx,
    input  wire logic                  framing_bit_exp,
    input  wire logic                  bipolar_violation,
    input  wire logic                  b8zs_substitution,
    input  wire logic                  b8zs_mode,
    input  wire logic                  activity_pulse,
    input  wire logic [24*10-1:0]      port_signals,
    input  wire logic                  left_btn,
    input  wire logic                  right_btn,
    input  wire logic                  view_next,
    output logic [7:0]                 seg_code,
    output logic [9:0]                 leds,
    output stat_pkg::tally_t           errored_second_tally,
    output stat_pkg::tally_t           checksum_mismatch_tally,
    output stat_pkg::tally_t           bursty_interval_tally,
    output stat_pkg::tally_t           fault_occurrence_tally,
    output stat_pkg::tally_t           heavy_fault_interval,
    output stat_pkg::tally_t           framing_bit_fault,
    output stat_pkg::tally_t           line_code_violation_tally,
    output logic                       second_tick
);
    import stat_pkg::*;

    // ==========================================
    // State
    typedef struct packed {
        logic [24:0] sec_cnt;
        tally_t      sec_crc;
        logic        sec_event;
        tally_t      es;
        tally_t      cr;
        tally_t      bs;
        tally_t      ee;
        tally_t      se;
        tally_t      fs;
        tally_t      lf;
        view_e       view;
        logic [4:0]  per_port_signal_view;
        logic [2:0]  node;
        logic [23:0] chase_cnt;
        logic [3:0]  chase_pos;
        logic [7:0]  act_cnt;
        logic [7:0]  act_rate;
        logic        tick;
        logic [7:0]  seg;
        logic [9:0]  led;
    } state_s;

    state_s s_q;
    state_s s_d;

    btn_if btn ();

    button_decoder u_buttons (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .left_btn  (left_btn),
        .right_btn (right_btn),
        .ev        (btn.producer)
    );

    // ==========================================
    // Event qualification
    logic crc_err;
    logic err_event;
    logic lcv_event;
    logic fbit_err;

    assign crc_err = frame_done && (crc_local != crc_rx);
    assign err_event = crc_err || loss_of_frame;
    assign lcv_event = bipolar_violation && !(b8zs_mode && b8zs_substitution);
    assign fbit_err = framing_bit_valid && (framing_bit_rx != framing_bit_exp);

    function automatic tally_t sat_inc(input tally_t v, input logic en);
        sat_inc = (en && v != 16'hffff) ? v + 16'h0001 : v;
    endfunction

    function automatic logic [7:0] seg_of(input view_e v, input logic [4:0] ch, input logic [2:0] nd);
        unique case (v)
            V_ACTIVITY:  seg_of = `SEG_ACT;
            V_ERR_SEC:   seg_of = `SEG_ES;
            V_CRC:       seg_of = `SEG_CRC;
            V_BURSTY:    seg_of = `SEG_BURST;
            V_EVENTS:    seg_of = `SEG_EE;
            V_SEVERE:    seg_of = `SEG_SE;
            V_FRAMING:   seg_of = `SEG_FS;
            V_LINE_CODE: seg_of = `SEG_LF;
            V_CHANNEL:   seg_of = {3'h0, ch + 5'h01};
            V_NODE:      seg_of = {4'h0, 1'b0, nd} + 8'h01;
            default:     seg_of = `SEG_ACT;
        endcase
    endfunction

    tally_t shown;

    // Wide product: rate times step overflows 24 bits above a rate of 55
    logic [31:0] chase_drop;
    assign chase_drop = 32'(s_q.act_rate) * 32'(`CHASE_STEP);

    always_comb begin
        unique case (s_q.view)
            V_ERR_SEC:   shown = s_q.es;
            V_CRC:       shown = s_q.cr;
            V_BURSTY:    shown = s_q.bs;
            V_EVENTS:    shown = s_q.ee;
            V_SEVERE:    shown = s_q.se;
            V_FRAMING:   shown = s_q.fs;
            V_LINE_CODE: shown = s_q.lf;
            default:     shown = '0;
        endcase
    end

    // ==========================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.sec_cnt == 25'(`SEC_CYCLES - 1)) begin
            s_d.sec_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.sec_cnt = s_q.sec_cnt + 25'h1;
        end
        s_d.sec_crc = sat_inc(s_q.sec_crc, crc_err);
        s_d.sec_event = s_q.sec_event || err_event;
        s_d.cr = sat_inc(s_q.cr, crc_err);
        s_d.ee = sat_inc(s_q.ee, err_event);
        s_d.fs = sat_inc(s_q.fs, fbit_err);
        s_d.lf = sat_inc(s_q.lf, lcv_event);
        s_d.act_cnt = (activity_pulse && s_q.act_cnt != `ACT_SAT) ? s_q.act_cnt + 8'h01 : s_q.act_cnt;
        if (s_d.tick) begin
            // Errored second, event in last cycle included
            s_d.es = sat_inc(s_q.es, s_q.sec_event || err_event);
            s_d.bs = sat_inc(s_q.bs, s_d.sec_crc > `BURST_LOW && s_d.sec_crc < `SEVERE_LIMIT);
            s_d.se = sat_inc(s_q.se, s_d.sec_crc >= `SEVERE_LIMIT);
            s_d.sec_crc = '0;
            s_d.sec_event = 1'b0;
            s_d.act_rate = s_d.act_cnt;
            s_d.act_cnt = '0;
        end
        if (btn.both_press) begin
            s_d.es = '0;
            s_d.cr = '0;
            s_d.bs = '0;
            s_d.ee = '0;
            s_d.se = '0;
            s_d.fs = '0;
            s_d.lf = '0;
        end
        // View stepping; node views fixed to left button
        if (view_next) begin
            s_d.view = (s_q.view == V_CHANNEL || s_q.view == V_NODE) ? V_ACTIVITY : view_e'(s_q.view + 4'h1);
        end
        if (btn.right_press && s_q.view == V_CHANNEL) begin
            s_d.per_port_signal_view = (s_q.per_port_signal_view == `LAST_CHANNEL) ? 5'h00 : s_q.per_port_signal_view + 5'h01;
        end
        if (btn.left_press) begin
            s_d.view = V_NODE;
            if (s_q.view == V_NODE) begin
                s_d.node = (s_q.node == `NUM_NODE_VIEWS) ? 3'h0 : s_q.node + 3'h1;
            end
        end
        if (s_q.chase_cnt == '0) begin
            s_d.chase_pos = (s_q.chase_pos == 4'(`NUM_LEDS - 1)) ? 4'h0 : s_q.chase_pos + 4'h1;
            s_d.chase_cnt = (chase_drop >= 32'(`CHASE_SLOW - `CHASE_FAST))
                ? `CHASE_FAST : `CHASE_SLOW - chase_drop[23:0];
        end else begin
            s_d.chase_cnt = s_q.chase_cnt - 24'h1;
        end
        s_d.seg = seg_of(s_d.view, s_d.per_port_signal_view, s_d.node);
        unique case (s_d.view)
            V_CHANNEL: s_d.led = port_signals[s_d.per_port_signal_view * 10 +: 10];
            V_ACTIVITY, V_NODE: s_d.led = 10'h200 >> s_d.chase_pos;
            default: s_d.led = shown[9:0];
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.chase_cnt <= `CHASE_SLOW;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs
    assign seg_code = s_q.seg;
    assign leds = s_q.led;
    assign second_tick = s_q.tick;
    assign errored_second_tally = s_q.es;
    assign checksum_mismatch_tally = s_q.cr;
    assign bursty_interval_tally = s_q.bs;
    assign fault_occurrence_tally = s_q.ee;
    assign heavy_fault_interval = s_q.se;
    assign framing_bit_fault = s_q.fs;
    assign line_code_violation_tally = s_q.lf;

    // ==========================================
    // Assertions
    a_crc_counts: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (crc_err && !btn.both_press && checksum_mismatch_tally != 16'hffff)
        |=> checksum_mismatch_tally == $past(checksum_mismatch_tally) + 16'h1)
        else $error("crc mismatch not counted");
    a_framing_counts: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (fbit_err && !btn.both_press && framing_bit_fault != 16'hffff)
        |=> framing_bit_fault == $past(framing_bit_fault) + 16'h1)
        else $error("framing fault not counted");
    a_b8zs_excused: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (b8zs_mode && b8zs_substitution && !btn.both_press)
        |=> line_code_violation_tally == $past(line_code_violation_tally))
        else $error("substitution counted as violation");
    a_event_sources: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (loss_of_frame && !btn.both_press && fault_occurrence_tally != 16'hffff)
        |=> fault_occurrence_tally == $past(fault_occurrence_tally) + 16'h1)
        else $error("loss of frame not an event");
    a_severe_band: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_q.sec_crc >= `SEVERE_LIMIT && s_d.tick && !btn.both_press)
        |=> heavy_fault_interval != $past(heavy_fault_interval) || heavy_fault_interval == 16'hffff)
        else $error("severe second missed");
    a_bursty_band: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_q.sec_crc >= `SEVERE_LIMIT && s_d.tick)
        |=> bursty_interval_tally == $past(bursty_interval_tally) || $past(btn.both_press))
        else $error("severe second counted bursty");
    a_errsec_clean: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_d.tick && !s_q.sec_event && !err_event)
        |=> errored_second_tally == $past(errored_second_tally) || $past(btn.both_press))
        else $error("clean second counted errored");
    a_lcv_counts: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (lcv_event && !btn.both_press && line_code_violation_tally != 16'hffff)
        |=> line_code_violation_tally == $past(line_code_violation_tally) + 16'h1)
        else $error("line code fault not counted");
    // Clear covers every tally, not only the interval ones
    sequence clear_request;
        btn.both_press;
    endsequence
    sequence all_tallies_zero;
        errored_second_tally == 16'h0 && checksum_mismatch_tally == 16'h0 && bursty_interval_tally == 16'h0
            && fault_occurrence_tally == 16'h0 && heavy_fault_interval == 16'h0 && framing_bit_fault == 16'h0
            && line_code_violation_tally == 16'h0;
    endsequence
    a_clear_both: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clear_request |=> all_tallies_zero)
        else $error("counters not cleared");
    // Release is only a click if both buttons sat low before it
    sequence right_click;
        (!left_btn && !right_btn) ##1 (right_btn && !left_btn) ##1 (!right_btn && !left_btn);
    endsequence
    a_per_port_signal_view_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (right_click ##0 (s_q.view == V_CHANNEL && s_q.per_port_signal_view != `LAST_CHANNEL))
        |=> s_q.per_port_signal_view == $past(s_q.per_port_signal_view) + 5'h01)
        else $error("channel did not step");
    a_per_port_signal_view_number: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_q.view == V_CHANNEL) |-> seg_code == {3'h0, s_q.per_port_signal_view + 5'h01})
        else $error("channel number not shown");
    a_node_wrap: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (btn.left_press && s_q.view == V_NODE && s_q.node == `NUM_NODE_VIEWS) |=> s_q.node == 3'h0)
        else $error("node view did not wrap");
    a_per_port_signal_view_wrap: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (btn.right_press && s_q.view == V_CHANNEL && s_q.per_port_signal_view == `LAST_CHANNEL) |=> s_q.per_port_signal_view == 5'h0)
        else $error("channel did not wrap at 24");
    a_tick_period: assert property (@(posedge clk_sys) disable iff (!reset_n)
        second_tick |=> !second_tick)
        else $error("second tick too long");
endmodule

// ### hw/stat_consts.svh
`ifndef STAT_CONSTS_SVH
`define STAT_CONSTS_SVH

// Clock rate and interval
`define CLK_HZ            20000000
`define SEC_CYCLES        (`CLK_HZ)
// Burst / severe thresholds
`define SEVERE_LIMIT      16'd320
`define BURST_LOW         16'd1
// Channels and views
`define NUM_CHANNELS      5'd24
`define LAST_CHANNEL      5'd23
`define NUM_NODE_VIEWS    3'd7
`define NUM_LEDS          10
// Chase stepping
`define CHASE_SLOW        24'd4000000
`define CHASE_STEP        24'd300000
`define CHASE_FAST        24'd200000
`define ACT_SAT           8'hff
// Seven-segment codes for the view names
`define SEG_ACT           8'hac
`define SEG_ES            8'he5
`define SEG_CRC           8'hc7
`define SEG_BURST         8'hb5
`define SEG_EE            8'hee
`define SEG_SE            8'h5e
`define SEG_FS            8'hf5
`define SEG_LF            8'h1f

`endif

// ### hw/stat_pkg.sv
package stat_pkg;
    typedef enum logic [3:0] {
        V_ACTIVITY,
        V_ERR_SEC,
        V_CRC,
        V_BURSTY,
        V_EVENTS,
        V_SEVERE,
        V_FRAMING,
        V_LINE_CODE,
        V_CHANNEL,
        V_NODE
    } view_e;
    typedef logic [15:0] tally_t;
endpackage

// ### test/line_error_stat_display_test.sv
`timescale 1ns/1ps
`include "stat_consts.svh"
module line_error_stat_display_test;
    import stat_pkg::*;
    logic           clk_sys = 1'b0;
    logic           reset_n = 1'b0;
    logic           view_next = 1'b0;
    logic [239:0]   port_signals;
    logic           frame_done, loss_of_frame, fb_valid, fb_rx, fb_exp;
    logic           bpv, b8sub, b8mode, left_btn, right_btn, second_tick;
    logic [5:0]     crc_local, crc_rx;
    logic [7:0]     seg_code;
    logic [9:0]     leds;
    tally_t         es_t, cr_t, bs_t, ee_t, se_t, fs_t, lf_t;
    int             errors = 0;
    int             cmp_count = 0;
    always #25 clk_sys = ~clk_sys;
    line_side_model line (.clk_sys(clk_sys), .frame_done(frame_done), .crc_local(crc_local), .crc_rx(crc_rx),
        .loss_of_frame(loss_of_frame), .framing_bit_valid(fb_valid), .framing_bit_rx(fb_rx),
        .framing_bit_exp(fb_exp), .bipolar_violation(bpv), .b8zs_substitution(b8sub), .b8zs_mode(b8mode),
        .left_btn(left_btn), .right_btn(right_btn));
    // Chase speed is out of reach in this run, so activity is tied
    line_error_stat_display dut (.clk_sys(clk_sys), .reset_n(reset_n), .frame_done(frame_done),
        .crc_local(crc_local), .crc_rx(crc_rx), .loss_of_frame(loss_of_frame), .framing_bit_valid(fb_valid),
        .framing_bit_rx(fb_rx), .framing_bit_exp(fb_exp), .bipolar_violation(bpv), .b8zs_substitution(b8sub),
        .b8zs_mode(b8mode), .activity_pulse(1'b0), .port_signals(port_signals), .left_btn(left_btn),
        .right_btn(right_btn), .view_next(view_next), .seg_code(seg_code), .leds(leds),
        .errored_second_tally(es_t), .checksum_mismatch_tally(cr_t), .bursty_interval_tally(bs_t),
        .fault_occurrence_tally(ee_t), .heavy_fault_interval(se_t), .framing_bit_fault(fs_t),
        .line_code_violation_tally(lf_t), .second_tick(second_tick));
    // ==========================================
    // Compare and close
    task automatic chk_tally(input tally_t got, input tally_t exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_disp(input logic [9:0] got, input logic [9:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic settle();
        repeat (3) line.step();
    endtask
    function automatic logic [9:0] per_port_signal_view_bits(input int n);
        return 10'(n * 41 + 5);
    endfunction
    // ==========================================
    // Scenarios
    task automatic t_idle();
        chk_disp(leds, 10'h200, "chase start");
        chk_disp({2'h0, seg_code}, {2'h0, `SEG_ACT}, "start view");
        chk_tally(es_t | bs_t | se_t, 16'h0, "interval tallies");
        chk_disp({9'h0, second_tick}, 10'h0, "no early tick");
    endtask
    task automatic t_crc();
        line.frame(6'h11, 6'h11);
        line.frame(6'h00, 6'h01);
        line.frame(6'h3f, 6'h1f);
        line.frame(6'h20, 6'h00);
        settle();
        chk_tally(cr_t, 16'h3, "crc mismatch");
        chk_tally(ee_t, 16'h3, "events after crc");
    endtask
    task automatic t_lof();
        line.lof(2);
        settle();
        chk_tally(ee_t, 16'h5, "events after lof");
        chk_tally(cr_t, 16'h3, "crc unchanged");
    endtask
    task automatic t_framing();
        line.fbit(1'b1, 1'b1, 1'b1);
        line.fbit(1'b1, 1'b0, 1'b1);
        line.fbit(1'b0, 1'b1, 1'b0);
        line.fbit(1'b1, 1'b1, 1'b0);
        settle();
        chk_tally(fs_t, 16'h2, "framing faults");
    endtask
    task automatic t_line_code();
        line.bpv(1'b0, 1'b1);
        line.bpv(1'b0, 1'b0);
        line.bpv(1'b1, 1'b1);
        line.bpv(1'b1, 1'b0);
        settle();
        chk_tally(lf_t, 16'h3, "line code");
    endtask
    task automatic t_clear();
        line.press(1'b1, 1'b1);
        chk_tally(cr_t | ee_t, 16'h0, "clear crc events");
        chk_tally(fs_t | lf_t, 16'h0, "clear framing code");
    endtask
    task automatic t_channel();
        repeat (8) begin
            view_next = 1'b1;
            line.step();
            view_next = 1'b0;
            line.step();
        end
        settle();
        chk_disp({2'h0, seg_code}, 10'd1, "first channel");
        chk_disp(leds, per_port_signal_view_bits(0), "channel leds");
        for (int k = 1; k <= 24; k++) begin
            line.press(1'b0, 1'b1);
            chk_disp({2'h0, seg_code}, 10'(k % 24 + 1), "channel step");
            chk_disp(leds, per_port_signal_view_bits(k % 24), "stepped leds");
        end
    endtask
    task automatic t_node();
        logic [7:0] first;
        line.press(1'b1, 1'b0);
        first = seg_code;
        chk_disp(10'(first >= 8'd1 && first <= 8'd8), 10'h1, "node range");
        chk_disp(leds, 10'h200, "node chase");
        for (int k = 1; k <= 8; k++) begin
            line.press(1'b1, 1'b0);
            chk_disp({2'h0, seg_code}, 10'((first + k - 1) % 8 + 1), "node step");
        end
    endtask
    initial begin
        for (int n = 0; n < 24; n++) port_signals[n*10 +: 10] = per_port_signal_view_bits(n);
        repeat (20) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        settle();
        t_idle();
        t_crc();
        t_lof();
        t_framing();
        t_line_code();
        t_clear();
        t_channel();
        t_node();
        finish_test();
    end
    initial begin
        #(50 * 5000);
        errors++;
        finish_test();
    end
endmodule

// ### test/line_side_model.sv
`timescale 1ns/1ps
// ==========================================
// Line receiver and operator stand-in
module line_side_model (
    input  wire logic       clk_sys,
    output logic            frame_done,
    output logic [5:0]      crc_local,
    output logic [5:0]      crc_rx,
    output logic            loss_of_frame,
    output logic            framing_bit_valid,
    output logic            framing_bit_rx,
    output logic            framing_bit_exp,
    output logic            bipolar_violation,
    output logic            b8zs_substitution,
    output logic            b8zs_mode,
    output logic            left_btn,
    output logic            right_btn
);
    initial begin
        {frame_done, loss_of_frame, framing_bit_valid, bipolar_violation} = 4'h0;
        {framing_bit_rx, framing_bit_exp, b8zs_substitution, b8zs_mode} = 4'h5;
        {left_btn, right_btn} = 2'h0;
        crc_local = 6'h15;
        crc_rx = 6'h2a;
    end
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    // Outside a frame the CRC lines carry junk: the inverted and the plain computed value
    task automatic frame(input logic [5:0] calc, input logic [5:0] rcv);
        crc_local = calc;
        crc_rx = rcv;
        frame_done = 1'b1;
        step();
        frame_done = 1'b0;
        crc_local = ~calc;
        crc_rx = calc;
        step();
    endtask
    task automatic lof(input int n);
        loss_of_frame = 1'b1;
        repeat (n) step();
        loss_of_frame = 1'b0;
    endtask
    task automatic fbit(input logic v, input logic rx, input logic ex);
        {framing_bit_valid, framing_bit_rx, framing_bit_exp} = {v, rx, ex};
        step();
        {framing_bit_valid, framing_bit_rx, framing_bit_exp} = {1'b0, ~rx, rx};
        step();
    endtask
    task automatic bpv(input logic mode, input logic sub);
        {b8zs_mode, b8zs_substitution, bipolar_violation} = {mode, sub, 1'b1};
        step();
        {b8zs_substitution, bipolar_violation} = {~sub, 1'b0};
        step();
    endtask
    // Single presses act on release, both buttons on press; allow settling edges after it
    task automatic press(input logic l, input logic r);
        {left_btn, right_btn} = {l, r};
        step();
        {left_btn, right_btn} = 2'h0;
        repeat (3) step();
    endtask
endmodule
